// ### rtl/ppc_pkg.sv
// package for the parameter protection and control method block
// assumes a single 20 MHz clock domain and a plain strobe register port
package ppc_pkg;
    // register addresses on the 16-bit parameter address bus
    localparam logic [15:0] PPC_ADDR_PWD_ENTRY  = 16'h0007;
    localparam logic [15:0] PPC_ADDR_PWD_SET    = 16'h8000;
    localparam logic [15:0] PPC_ADDR_CTRL_METH  = 16'h000A;
    localparam logic [15:0] PPC_ADDR_VEL_SCHEME = 16'h000B;
    localparam logic [15:0] PPC_ADDR_TRQ_SCHEME = 16'h000D;
    localparam logic [15:0] PPC_ADDR_MOTOR_TYPE = 16'h0521;
    localparam logic [15:0] PPC_ADDR_IRQ_STAT   = 16'hF000;
    localparam logic [15:0] PPC_ADDR_IRQ_MASK   = 16'hF001;
    localparam logic [15:0] PPC_ADDR_STATUS     = 16'hF002;
    // reset values
    localparam logic [15:0] PPC_RST_CTRL_METH   = 16'h0000;
    localparam logic [15:0] PPC_RST_VEL_SCHEME  = 16'h0000;
    localparam logic [15:0] PPC_RST_PWD         = 16'h0000;
    localparam logic [15:0] PPC_RST_TRQ_SCHEME  = 16'h0000;
    localparam logic [15:0] PPC_RST_MOTOR_TYPE  = 16'h0000;
    // encodings
    localparam logic [15:0] PPC_METH_VELOCITY   = 16'h0000;
    localparam logic [15:0] PPC_METH_TORQUE     = 16'h0002;
    localparam logic [15:0] PPC_VEL_SVC         = 16'h0002;
    localparam logic [15:0] PPC_VEL_MAX_LOW     = 16'h0005;
    localparam logic [15:0] PPC_VEL_IPM         = 16'h0007;
    localparam logic [15:0] PPC_MOTOR_PM_MAX    = 16'h0002;
    localparam logic [15:0] PPC_RESET_CODE      = 16'h270F; // 9999
    localparam logic [2:0]  PPC_MAX_FAILS       = 3'h4;
    // irq status bit positions
    localparam int PPC_IRQ_FAIL    = 0;
    localparam int PPC_IRQ_LOCK    = 1;
    localparam int PPC_IRQ_UNLOCK  = 2;
    localparam int PPC_IRQ_FACTORY = 3;
    localparam int PPC_IRQ_W       = 4;
    // timing
    localparam longint PPC_CLK_HZ        = 20000000;
    localparam longint PPC_RESET_WIN_S   = 10;
    localparam longint PPC_RESET_WIN_CYC = PPC_RESET_WIN_S * PPC_CLK_HZ;
    localparam longint PPC_FLASH_MS      = 250;
    localparam longint PPC_FLASH_CYC     = PPC_FLASH_MS * PPC_CLK_HZ / 1000;

    // bus request bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ppc_req_t;

    // decoded control state shown to the drive core
    typedef struct packed {
        logic        velocity_active;
        logic        torque_active;
        logic [2:0]  vel_scheme;
        logic [1:0]  trq_scheme;
        logic        motor_is_pm;
    } ppc_mode_t;
endpackage

// ### rtl/ppc_param_protect.sv
// parameter protection, lockout, factory reset and control mode registers
// assumes a synchronous master on mclk driving one-cycle strobes
//
// Contract
// - each wrong password increments shown fail count
// - fourth wrong password locks keypad, flashing indication
// - lockout refuses attempts until reboot
// - reset code twice within window restores defaults
// - setting reads one protected, zero otherwise
// - correct password lifts protection, setting reads zero
// - temporary unlock rearms at reboot (here reboot also clears the stored password, so protection stays off)
// - writing zero to setting disables protection permanently
// - copy allowed only while protection inactive
// - stored password never offered to copy
// - control method: velocity zero, torque two
// - velocity scheme accepts 0..5 and 7
// - velocity scheme applies only under velocity method
// - svc motor type: zero induction, one/two pm
// - protected reads return zero except setting
// - entries compared against stored password
`timescale 1ns/1ps
module ppc_param_protect
    import ppc_pkg::*;
#(
    parameter longint RESET_WIN_CYC = PPC_RESET_WIN_CYC,
    parameter longint FLASH_CYC     = PPC_FLASH_CYC
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic      [1:0]  fail_count,
    output logic             keypad_locked,
    output logic             lock_flash,
    output logic             copy_allowed,
    output logic             factory_reset,
    output ppc_mode_t        mode,
    output logic             irq
);
    // bundle the bus inputs
    ppc_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // address match helper, used by write and read decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    // stored state
    logic [15:0] pwd_q,  pwd_d;        // stored password, zero means none
    logic        perm_q, perm_d;       // protection disabled permanently
    logic        unl_q,  unl_d;        // unlocked by entry, this boot only
    logic [2:0]  fails_q, fails_d;     // wrong entries since reboot
    logic        first9_q, first9_d;   // first reset code seen
    logic [31:0] win_q,  win_d;        // reset window countdown
    logic [15:0] meth_q, meth_d;       // control method
    logic [15:0] vel_q,  vel_d;        // velocity scheme
    logic [15:0] trq_q,  trq_d;        // torque scheme
    logic [15:0] mot_q,  mot_d;        // motor type
    logic [PPC_IRQ_W-1:0] ist_q, ist_d; // sticky events
    logic [PPC_IRQ_W-1:0] imsk_q;      // event mask
    logic [31:0] flc_q;                // flash divider
    logic        fl_q;                 // flash phase
    logic [15:0] rdata_q;
    logic        frst_q;

    // protection state decode
    wire protected_now = (pwd_q != 16'h0000) && !perm_q && !unl_q;
    wire locked        = fails_q >= PPC_MAX_FAILS;

    // write decode
    wire wr_entry = req.wr && hit(req.addr, PPC_ADDR_PWD_ENTRY);
    // only the entry parameter is writable while protected
    wire wr_ok    = req.wr && !protected_now;
    wire wr_set   = wr_ok && hit(req.addr, PPC_ADDR_PWD_SET);
    wire wr_meth  = wr_ok && hit(req.addr, PPC_ADDR_CTRL_METH);
    wire wr_vel   = wr_ok && hit(req.addr, PPC_ADDR_VEL_SCHEME);
    wire wr_trq   = wr_ok && hit(req.addr, PPC_ADDR_TRQ_SCHEME);
    wire wr_mot   = wr_ok && hit(req.addr, PPC_ADDR_MOTOR_TYPE);
    wire wr_ist   = wr_ok && hit(req.addr, PPC_ADDR_IRQ_STAT);
    wire wr_imsk  = wr_ok && hit(req.addr, PPC_ADDR_IRQ_MASK);

    // entry classification; a locked keypad takes no attempt
    wire entry_live = wr_entry && !locked;
    wire is_code    = req.wdata == PPC_RESET_CODE;
    wire win_open   = win_q != 32'h0;
    wire do_factory = entry_live && is_code && first9_q && win_open;
    wire pwd_match  = req.wdata == pwd_q;
    wire ent_good   = entry_live && protected_now && pwd_match;
    // reset code is not counted as a wrong guess
    wire ent_bad    = entry_live && protected_now && !pwd_match && !is_code;

    // value legality checks
    wire meth_legal = (req.wdata == PPC_METH_VELOCITY) ||
                      (req.wdata == PPC_METH_TORQUE);
    wire vel_legal  = (req.wdata <= PPC_VEL_MAX_LOW) ||
                      (req.wdata == PPC_VEL_IPM);
    wire mot_legal  = req.wdata <= PPC_MOTOR_PM_MAX;

    // next state for protection
    always_comb begin
        pwd_d    = pwd_q;
        perm_d   = perm_q;
        unl_d    = unl_q;
        fails_d  = fails_q;
        first9_d = first9_q;
        win_d    = win_open ? win_q - 32'h1 : win_q;
        if (ent_bad) begin
            fails_d = fails_q + 3'h1;
        end
        if (ent_good) begin
            unl_d = 1'b1;
        end
        if (entry_live && is_code && !do_factory) begin
            first9_d = 1'b1;
            win_d    = RESET_WIN_CYC[31:0];
        end else if (entry_live && !is_code) begin
            first9_d = 1'b0;                 // other entry breaks pair
        end else if (!win_open) begin
            first9_d = 1'b0;
        end
        if (wr_set) begin
            if (req.wdata == 16'h0000) begin
                perm_d = 1'b1;
                pwd_d  = 16'h0000;
            end else begin
                pwd_d  = req.wdata;
                perm_d = 1'b0;
                unl_d  = 1'b0;
            end
        end
        if (do_factory) begin
            pwd_d    = PPC_RST_PWD;
            perm_d   = 1'b0;
            unl_d    = 1'b0;
            fails_d  = 3'h0;
            first9_d = 1'b0;
            win_d    = 32'h0;
        end
    end

    // next state for mode registers, illegal method, velocity and motor codes ignored; torque scheme taken unchecked
    always_comb begin
        meth_d = wr_meth && meth_legal ? req.wdata : meth_q;
        vel_d  = wr_vel && vel_legal ? req.wdata : vel_q;
        trq_d  = wr_trq ? req.wdata : trq_q;
        mot_d  = wr_mot && mot_legal ? req.wdata : mot_q;
        if (do_factory) begin
            meth_d = PPC_RST_CTRL_METH;
            vel_d  = PPC_RST_VEL_SCHEME;
            trq_d  = PPC_RST_TRQ_SCHEME;
            mot_d  = PPC_RST_MOTOR_TYPE;
        end
    end

    // event sticky bits: set beats write-one-clear
    wire [PPC_IRQ_W-1:0] ev;
    assign ev[PPC_IRQ_FAIL]    = ent_bad;
    assign ev[PPC_IRQ_LOCK]    = ent_bad && (fails_q == PPC_MAX_FAILS - 3'h1);
    assign ev[PPC_IRQ_UNLOCK]  = ent_good;
    assign ev[PPC_IRQ_FACTORY] = do_factory;
    always_comb begin
        ist_d = ist_q;
        if (wr_ist) begin
            ist_d = ist_q & ~req.wdata[PPC_IRQ_W-1:0];
        end
        ist_d = ist_d | ev;
    end

    // read mux; reboot (resetn) clears the temporary unlock
    wire [15:0] set_view = {15'h0, protected_now};
    wire [15:0] sta_view = {11'h0, copy_allowed, fl_q, locked, fails_q[1:0]};
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (hit(req.addr, PPC_ADDR_PWD_SET)) begin
            rd_mux = set_view;           // password itself is never read
        end else if (protected_now) begin
            rd_mux = 16'h0000;
        end else if (hit(req.addr, PPC_ADDR_CTRL_METH)) begin
            rd_mux = meth_q;
        end else if (hit(req.addr, PPC_ADDR_VEL_SCHEME)) begin
            rd_mux = vel_q;
        end else if (hit(req.addr, PPC_ADDR_TRQ_SCHEME)) begin
            rd_mux = trq_q;
        end else if (hit(req.addr, PPC_ADDR_MOTOR_TYPE)) begin
            rd_mux = mot_q;
        end else if (hit(req.addr, PPC_ADDR_IRQ_STAT)) begin
            rd_mux = {12'h0, ist_q};
        end else if (hit(req.addr, PPC_ADDR_IRQ_MASK)) begin
            rd_mux = {12'h0, imsk_q};
        end else if (hit(req.addr, PPC_ADDR_STATUS)) begin
            rd_mux = sta_view;
        end
    end

    // mode decode for the drive core, taken from next values so that a
    // write shows on the mode output one cycle after its strobe
    ppc_mode_t mode_d;
    always_comb begin
        mode_d.velocity_active = meth_d == PPC_METH_VELOCITY;
        mode_d.torque_active   = meth_d == PPC_METH_TORQUE;
        // velocity scheme held at zero unless velocity method selected
        mode_d.vel_scheme  = mode_d.velocity_active ?
                             vel_d[2:0] : 3'h0;
        mode_d.trq_scheme  = mode_d.torque_active ? trq_d[1:0] : 2'h0;
        mode_d.motor_is_pm = mode_d.velocity_active &&
                             (vel_d == PPC_VEL_SVC) &&
                             (mot_d != 16'h0000);
    end

    // state registers; reboot clears temporary unlock, fails and the stored password
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pwd_q    <= PPC_RST_PWD;
            perm_q   <= 1'b0;
            unl_q    <= 1'b0;
            fails_q  <= 3'h0;
            first9_q <= 1'b0;
            win_q    <= 32'h0;
        end else begin
            pwd_q    <= pwd_d;
            perm_q   <= perm_d;
            unl_q    <= unl_d;
            fails_q  <= fails_d;
            first9_q <= first9_d;
            win_q    <= win_d;
        end
    end

    // mode and interrupt registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meth_q <= PPC_RST_CTRL_METH;
            vel_q  <= PPC_RST_VEL_SCHEME;
            trq_q  <= PPC_RST_TRQ_SCHEME;
            mot_q  <= PPC_RST_MOTOR_TYPE;
            ist_q  <= '0;
            imsk_q <= '0;
        end else begin
            meth_q <= meth_d;
            vel_q  <= vel_d;
            trq_q  <= trq_d;
            mot_q  <= mot_d;
            ist_q  <= ist_d;
            if (wr_imsk) begin
                imsk_q <= req.wdata[PPC_IRQ_W-1:0];
            end
        end
    end

    // lockout flash divider runs only while locked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flc_q <= 32'h0;
            fl_q  <= 1'b0;
        end else if (!locked) begin
            flc_q <= 32'h0;
            fl_q  <= 1'b0;
        end else if (flc_q >= FLASH_CYC[31:0] - 32'h1) begin
            flc_q <= 32'h0;
            fl_q  <= ~fl_q;
        end else begin
            flc_q <= flc_q + 32'h1;
        end
    end

    // registered outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q       <= 16'h0000;
            fail_count    <= 2'h0;
            keypad_locked <= 1'b0;
            lock_flash    <= 1'b0;
            copy_allowed  <= 1'b1;
            frst_q        <= 1'b0;
            mode          <= '0;
            irq           <= 1'b0;
        end else begin
            rdata_q       <= req.rd ? rd_mux : 16'h0000;
            // count shows 1..3; fourth is shown as lockout
            fail_count    <= fails_d[1:0];
            keypad_locked <= fails_d >= PPC_MAX_FAILS;
            lock_flash    <= fl_q;
            // copy never carries the password (no path to pwd_q)
            copy_allowed  <= !((pwd_d != 16'h0000) && !perm_d
                               && !unl_d);
            frst_q        <= do_factory;
            mode          <= mode_d;
            irq           <= |(ist_d & imsk_q);
        end
    end

    assign reg_rdata     = rdata_q;
    assign factory_reset = frst_q;
endmodule

// ### dv/ppc_param_protect_properties.sv
// port-level checker for the protection block
// assumes one mclk domain; bound onto ppc_param_protect below
`timescale 1ns/1ps
module ppc_protect_chk
    import ppc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0]  fail_count,
    input wire logic        keypad_locked,
    input wire logic        lock_flash,
    input wire logic        copy_allowed,
    input wire logic        factory_reset,
    input wire ppc_mode_t   mode,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // protection state is taken from copy permission; setting reads show it too
    wire prot = !copy_allowed;

    AST_LOCK_HOLD: assert property (keypad_locked |=> keypad_locked)
        else $error("lock dropped without reboot");
    AST_FLASH_LOCKED: assert property (!keypad_locked |-> !lock_flash)
        else $error("flash while unlocked");
    AST_LOCK_NO_ENTRY: assert property (keypad_locked && reg_wr
        && reg_addr == PPC_ADDR_PWD_ENTRY |=> keypad_locked && prot)
        else $error("entry taken while locked");
    AST_FAIL_STEP: assert property ($changed(fail_count) |->
        fail_count == $past(fail_count) + 2'h1 || fail_count == 2'h0)
        else $error("fail count jumped");
    AST_PROT_READ_ZERO: assert property (prot && reg_rd
        && reg_addr != PPC_ADDR_PWD_SET |=> reg_rdata == 16'h0000)
        else $error("protected read leaked data");
    AST_SET_READ: assert property (reg_rd && reg_addr == PPC_ADDR_PWD_SET
        |=> reg_rdata == {15'h0000, $past(prot)})
        else $error("setting read mismatch");
    AST_PROT_WRITE: assert property (prot && reg_wr
        && reg_addr == PPC_ADDR_CTRL_METH |=> $stable(mode))
        else $error("protected write took effect");
    AST_VEL_SIX: assert property (reg_wr && reg_wdata == 16'h0006
        && reg_addr == PPC_ADDR_VEL_SCHEME |=> $stable(mode))
        else $error("unused velocity code taken");
    AST_VEL_GATED: assert property (!mode.velocity_active
        |-> mode.vel_scheme == 3'h0)
        else $error("velocity scheme outside velocity method");
    AST_MODE_ONE: assert property (!(mode.velocity_active
        && mode.torque_active))
        else $error("two control methods at once");
    AST_FACTORY: assert property (factory_reset |=> !factory_reset
        && fail_count == 2'h0 && !mode.torque_active)
        else $error("factory restore incomplete");

    COV_LOCK: cover property ($rose(keypad_locked));
    COV_FACTORY: cover property (factory_reset);
    COV_UNLOCK: cover property ($rose(copy_allowed));
endmodule

bind ppc_param_protect ppc_protect_chk chk_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fail_count(fail_count),
    .keypad_locked(keypad_locked), .lock_flash(lock_flash),
    .copy_allowed(copy_allowed), .factory_reset(factory_reset),
    .mode(mode), .irq(irq));

// ### dv/ppc_keypad_model.sv
// keypad or communication master model for the protection block
// assumes it is the only master and shares mclk with the block
`timescale 1ns/1ps
module ppc_keypad_model
    import ppc_pkg::*;
#(
    parameter bit CARD_FITTED = 1'b1 // encoder card present
) (
    input  wire logic        mclk,
    input  wire logic [15:0] rdata,
    output ppc_req_t         req
);
    initial req = '0;
    // one write cycle; data inverted after release, not left stale
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr    <= 1'b0;
        req.wdata <= ~d;
        #1;
    endtask
    // one read cycle; data stands only in the following cycle
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // operator keys the reset code once; call twice for a restore
    task automatic key_reset_code;
        wr(PPC_ADDR_PWD_ENTRY, PPC_RESET_CODE);
    endtask
    // pulse feedback needs encoder v/f velocity scheme
    task automatic key_pulse_feedback;
        wr(PPC_ADDR_VEL_SCHEME, 16'h0001);
    endtask
endmodule

// ### dv/test_ppc_param_protect.sv
// self-checking bench for the protection block
// assumes the keypad model is the only master of the register port
`timescale 1ns/1ps
module test_ppc_param_protect;
    import ppc_pkg::*;
    localparam longint WIN = 50; // shortened restore window
    localparam longint FLS = 4;  // shortened flash period
    logic        mclk, resetn, locked, flash, copy_ok, fac, irq, f;
    logic [15:0] rdata, d;
    logic [1:0]  fails;
    ppc_req_t    req;
    ppc_mode_t   mode;
    int          mismatches, comparisons, fac_seen;

    ppc_keypad_model kp (.mclk(mclk), .rdata(rdata), .req(req));
    ppc_param_protect #(.RESET_WIN_CYC(WIN), .FLASH_CYC(FLS)) uut (
        .mclk(mclk), .resetn(resetn), .reg_addr(req.addr),
        .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd),
        .reg_rdata(rdata), .fail_count(fails), .keypad_locked(locked),
        .lock_flash(flash), .copy_allowed(copy_ok),
        .factory_reset(fac), .mode(mode), .irq(irq));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // count restore pulses, one per cycle high
    always @(posedge mclk) if (fac === 1'b1) fac_seen <= fac_seen + 1;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        kp.rd(a, d);
        chk(d, exp);
    endtask
    // reboot: reset held eight cycles
    task automatic reboot;
        resetn <= 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hang is cut well past the expected few hundred cycles
    initial begin
        #500000;
        mismatches++;
        print_verdict;
    end

    initial begin
        resetn = 1'b0;
        fac_seen = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rchk(PPC_ADDR_CTRL_METH, PPC_RST_CTRL_METH);
        rchk(PPC_ADDR_PWD_SET, PPC_RST_PWD);
        kp.wr(16'h1234, 16'hFFFF);
        rchk(16'h1234, 16'h0000);
        chk({15'h0, copy_ok}, 16'h0001);
        // every velocity code; six is refused and five stays
        for (int i = 0; i < 8; i++) begin
            kp.wr(PPC_ADDR_VEL_SCHEME, 16'(i));
            rchk(PPC_ADDR_VEL_SCHEME, (i == 6) ? 16'h0005 : 16'(i));
        end
        chk({13'h0, mode.vel_scheme}, 16'h0007);
        kp.wr(PPC_ADDR_CTRL_METH, PPC_METH_TORQUE);
        chk({15'h0, mode.torque_active}, 16'h0001);
        chk({13'h0, mode.vel_scheme}, 16'h0000);
        kp.wr(PPC_ADDR_CTRL_METH, 16'h0001);
        rchk(PPC_ADDR_CTRL_METH, PPC_METH_TORQUE);
        kp.wr(PPC_ADDR_CTRL_METH, PPC_METH_VELOCITY);
        chk({15'h0, mode.velocity_active}, 16'h0001);
        kp.key_pulse_feedback;
        rchk(PPC_ADDR_VEL_SCHEME, 16'h0001);
        // motor type under sensorless vector
        kp.wr(PPC_ADDR_VEL_SCHEME, PPC_VEL_SVC);
        kp.wr(PPC_ADDR_MOTOR_TYPE, 16'h0001);
        chk({15'h0, mode.motor_is_pm}, 16'h0001);
        kp.wr(PPC_ADDR_MOTOR_TYPE, 16'h0003);
        rchk(PPC_ADDR_MOTOR_TYPE, 16'h0001);
        kp.wr(PPC_ADDR_MOTOR_TYPE, 16'h0000);
        chk({15'h0, mode.motor_is_pm}, 16'h0000);
        // protect, miss three times, then unlock
        kp.wr(PPC_ADDR_IRQ_MASK, 16'h000F);
        kp.wr(PPC_ADDR_PWD_SET, 16'h1234);
        rchk(PPC_ADDR_PWD_SET, 16'h0001);
        chk({15'h0, copy_ok}, 16'h0000);
        rchk(PPC_ADDR_VEL_SCHEME, 16'h0000);
        kp.wr(PPC_ADDR_VEL_SCHEME, 16'h0000);
        kp.wr(PPC_ADDR_CTRL_METH, PPC_METH_TORQUE);
        chk({15'h0, mode.torque_active}, 16'h0000);
        for (int i = 1; i < 4; i++) begin
            kp.wr(PPC_ADDR_PWD_ENTRY, 16'h4321);
            chk({14'h0, fails}, 16'(i));
        end
        chk({15'h0, irq}, 16'h0001);
        kp.wr(PPC_ADDR_PWD_ENTRY, 16'h1234);
        rchk(PPC_ADDR_PWD_SET, 16'h0000);
        chk({15'h0, copy_ok}, 16'h0001);
        rchk(PPC_ADDR_VEL_SCHEME, PPC_VEL_SVC);
        rchk(PPC_ADDR_IRQ_STAT, 16'h0005);
        kp.wr(PPC_ADDR_IRQ_STAT, 16'h0005);
        rchk(PPC_ADDR_IRQ_STAT, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        kp.wr(PPC_ADDR_IRQ_MASK, 16'h0000);
        // first of four misses is the fourth since reboot and locks the keypad; masked events keep irq low
        kp.wr(PPC_ADDR_PWD_SET, 16'h1234);
        repeat (4) kp.wr(PPC_ADDR_PWD_ENTRY, 16'h4321);
        chk({15'h0, locked}, 16'h0001);
        chk({14'h0, fails}, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        f = flash;
        repeat (FLS) @(posedge mclk);
        #1 chk({15'h0, flash}, {15'h0, ~f});
        kp.wr(PPC_ADDR_PWD_ENTRY, 16'h1234);
        rchk(PPC_ADDR_PWD_SET, 16'h0001);
        reboot;
        chk({15'h0, locked}, 16'h0000);
        // restore: a late second code only opens a new window
        kp.wr(PPC_ADDR_CTRL_METH, PPC_METH_TORQUE);
        kp.wr(PPC_ADDR_PWD_SET, 16'h1234);
        kp.key_reset_code;
        repeat (WIN + 10) @(posedge mclk);
        kp.key_reset_code;
        chk(16'(fac_seen), 16'h0000);
        kp.key_reset_code;
        @(posedge mclk);
        #1 chk(16'(fac_seen), 16'h0001);
        rchk(PPC_ADDR_PWD_SET, 16'h0000);
        rchk(PPC_ADDR_CTRL_METH, PPC_RST_CTRL_METH);
        chk({14'h0, fails}, 16'h0000);
        print_verdict;
    end
endmodule
